// file: rds_block_readout_status.sv
`timescale 1ns/1ps
`include "rds_readout_defines.svh"
module rds_block_readout_status #(
    parameter int PULSE_CYCLES = `READY_PULSE_NS / `MCLK_PERIOD_NS
) (
    input  wire logic                   mclk,                  // core clock, 20 MHz
    input  wire logic                   rst_n,                 // asynchronous reset, active low
    input  wire logic                   group_valid,           // decoder: one-cycle pulse, new group
    input  wire rds_readout_pkg::group_s group_in,             // decoder: group contents
    input  wire logic                   station_detected,      // tuned channel is a station
    input  wire logic                   tuner_ready_flag,      // tuner settled
    input  wire logic                   interface_mode,        // strap pin, low two-wire, high three-wire
    input  wire logic                   sclk,                  // serial bus clock from host
    input  wire logic                   serial_latch_enable_n, // three-wire frame, active low
    input  wire logic                   sdio_in,               // serial data seen on the pin
    output logic                        sdio_out,              // serial data driven by device
    output logic                        sdio_oe,               // high while device drives sdio
    output logic                        two_wire_selected,     // enables the external two-wire engine
    output logic                        new_group_ready_flag,  // group ready indication
    output logic                        rbds_mode              // mirror of control bit 13
);
    localparam int CW = 20;

    generate
        if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << CW)) begin : g_bad
            $error("PULSE_CYCLES out of range for the pulse counter");
        end
    endgenerate

    // reset released through two flops
    logic rst_meta_reg;
    logic rst_sync_n;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // all bus pins and the strap cross into mclk here
    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    rds_readout_pkg::pins_s pins;

    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .mclk   (mclk),
        .rst_n  (rst_sync_n),
        .pin_in ({interface_mode, sdio_in, serial_latch_enable_n, sclk}),
        .level  (pin_level),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    assign pins.sclk      = pin_level[0];
    assign pins.sclk_rise = pin_rise[0];
    assign pins.sclk_fall = pin_fall[0];
    assign pins.sen_n     = pin_level[1];
    assign pins.sdio      = pin_level[2];
    assign pins.mode      = pin_level[3];

    // strap decides the protocol
    logic three_wire;
    assign three_wire        = pins.mode;
    assign two_wire_selected = ~three_wire;

    // group holding registers
    rds_readout_pkg::group_s group_reg;
    logic                    station_reg;
    logic                    tuner_ready_reg;
    logic [15:0]             ctrl_reg;

    // one load for the whole group so a read never mixes two groups
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            group_reg <= '0;
        end else if (group_valid) begin
            group_reg <= group_in;
        end
    end

    // live status inputs registered every cycle; the read word captures them once at command end
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            station_reg     <= 1'b0;
            tuner_ready_reg <= 1'b0;
        end else begin
            station_reg     <= station_detected;
            tuner_ready_reg <= tuner_ready_flag;
        end
    end

    logic clear_mode;
    logic verbose_on;
    assign clear_mode = ctrl_reg[`CTRL_CLEAR_MODE];
    assign verbose_on = ctrl_reg[`CTRL_VERBOSE];
    assign rbds_mode  = ctrl_reg[`CTRL_RBDS];

    // error levels read as zero outside verbose mode, where they mean nothing
    logic [1:0] err_first;
    logic [1:0] err_second;
    logic [1:0] err_third;
    logic [1:0] err_fourth;
    assign err_first  = verbose_on ? group_reg.first_block_error_level  : 2'h0;
    assign err_second = verbose_on ? group_reg.second_block_error_level : 2'h0;
    assign err_third  = verbose_on ? group_reg.third_block_error_level  : 2'h0;
    assign err_fourth = verbose_on ? group_reg.fourth_block_error_level : 2'h0;

    // status and late-error words
    logic [15:0] station_word;
    logic [15:0] late_err_word;
    logic [15:0] ready_word;
    always_comb begin
        station_word = 16'h0000;
        station_word[`STATION_BIT]     = station_reg;
        station_word[`TUNER_READY_BIT] = tuner_ready_reg;
        station_word[`IDENTITY_E_BIT]  = group_reg.block_identity_is_e;
        station_word[`FIRST_ERR_LSB +: 2]  = err_first;
        station_word[`SECOND_ERR_LSB +: 2] = err_second;
        late_err_word = 16'h0000;
        late_err_word[`THIRD_ERR_LSB +: 2]  = err_third;
        late_err_word[`FOURTH_ERR_LSB +: 2] = err_fourth;
        ready_word = 16'h0000;
        ready_word[`READY_FLAG_BIT] = new_group_ready_flag;
    end

    // three-wire frame: 8 command bits (read flag, index) then 16 data bits
    logic [4:0]  bit_cnt_reg;
    logic [7:0]  cmd_reg;
    logic [15:0] wdata_reg;
    logic [15:0] shift_reg;
    logic        frame_on;
    logic        cmd_done;
    logic        is_read;
    logic [6:0]  index;
    logic [15:0] read_word;
    assign frame_on = three_wire & ~pins.sen_n;
    assign cmd_done = pins.sclk_rise & frame_on & (bit_cnt_reg == `CMD_BITS - 5'd1);
    assign is_read  = cmd_reg[7];
    assign index    = cmd_reg[6:0];

    // the index arrives with the last command bit, so decode from the shifted value
    logic [7:0] cmd_next;
    assign cmd_next  = {cmd_reg[6:0], pins.sdio};
    assign read_word = (cmd_next[6:0] == `IDX_FIRST_BLOCK)  ? group_reg.first_block_word  :
                       (cmd_next[6:0] == `IDX_SECOND_BLOCK) ? group_reg.second_block_word :
                       (cmd_next[6:0] == `IDX_THIRD_BLOCK)  ? group_reg.third_block_word  :
                       (cmd_next[6:0] == `IDX_FOURTH_BLOCK) ? group_reg.fourth_block_word :
                       (cmd_next[6:0] == `IDX_LATE_ERRORS)  ? late_err_word               :
                       (cmd_next[6:0] == `IDX_STATION)      ? station_word                :
                       (cmd_next[6:0] == `IDX_READY_STATUS) ? ready_word                  :
                       (cmd_next[6:0] == `IDX_CTRL)         ? ctrl_reg                    :
                       16'h0000;

    // bit counter and input shifting; a frame restarts whenever the enable goes high
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt_reg <= 5'd0;
            cmd_reg     <= 8'h00;
            wdata_reg   <= 16'h0000;
        end else if (!frame_on) begin
            bit_cnt_reg <= 5'd0;
        end else if (pins.sclk_rise && bit_cnt_reg != `FRAME_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg < `CMD_BITS) begin
                cmd_reg <= cmd_next;
            end else begin
                wdata_reg <= {wdata_reg[14:0], pins.sdio};
            end
        end
    end

    // write completes on the 24th rising edge; only the control word accepts it
    logic write_done;
    assign write_done = frame_on & pins.sclk_rise & ~is_read & (bit_cnt_reg == `FRAME_BITS - 5'd1);
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (write_done && index == `IDX_CTRL) begin
            ctrl_reg <= {wdata_reg[14:0], pins.sdio};
        end
    end

    // read data goes out on falling edges so the host samples on rising edges
    logic reading_reg;
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_reg   <= 16'h0000;
            sdio_out    <= 1'b0;
            reading_reg <= 1'b0;
        end else if (!frame_on) begin
            reading_reg <= 1'b0;
        end else if (cmd_done) begin
            shift_reg   <= read_word;
            reading_reg <= cmd_next[7];
        end else if (pins.sclk_fall && reading_reg) begin
            sdio_out  <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'b0};
        end
    end
    assign sdio_oe = reading_reg & frame_on;

    // ready flag: set by a new group, cleared by a first-block read in clear mode or by pulse timeout otherwise
    logic          read_first;
    logic [CW-1:0] pulse_cnt_reg;
    logic          pulse_end;
    assign read_first = cmd_done & cmd_next[7] & (cmd_next[6:0] == `IDX_FIRST_BLOCK);
    assign pulse_end  = ~clear_mode & (pulse_cnt_reg == CW'(1));
    // set wins over either clear so no group is lost
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            new_group_ready_flag <= 1'b0;
            pulse_cnt_reg        <= '0;
        end else if (group_valid) begin
            new_group_ready_flag <= 1'b1;
            pulse_cnt_reg        <= CW'(PULSE_CYCLES);
        end else begin
            if (pulse_cnt_reg != '0) begin
                pulse_cnt_reg <= pulse_cnt_reg - CW'(1);
            end
            if ((clear_mode && read_first) || pulse_end) begin
                new_group_ready_flag <= 1'b0;
            end
        end
    end
endmodule

// file: rds_readout_defines.svh
`ifndef RDS_READOUT_DEFINES_SVH
`define RDS_READOUT_DEFINES_SVH

// register indexes on the serial control bus
`define IDX_CTRL          7'h04
`define IDX_READY_STATUS  7'h0a
`define IDX_STATION       7'h0b
`define IDX_FIRST_BLOCK   7'h0c
`define IDX_SECOND_BLOCK  7'h0d
`define IDX_THIRD_BLOCK   7'h0e
`define IDX_FOURTH_BLOCK  7'h0f
`define IDX_LATE_ERRORS   7'h10

// control word fields and reset value
`define CTRL_RESET        16'h0400
`define CTRL_CLEAR_MODE   10
`define CTRL_VERBOSE      7
`define CTRL_RBDS         13

// status word fields
`define READY_FLAG_BIT    15
`define STATION_BIT       8
`define TUNER_READY_BIT   7
`define IDENTITY_E_BIT    4
`define FIRST_ERR_LSB     2
`define SECOND_ERR_LSB    0
`define THIRD_ERR_LSB     14
`define FOURTH_ERR_LSB    12

// three-wire frame layout
`define CMD_BITS          5'd8
`define FRAME_BITS        5'd24

// timing
`define MCLK_PERIOD_NS    50
`define READY_PULSE_NS    40000000

`endif

// file: rds_readout_pkg.sv
package rds_readout_pkg;

    // one decoded group as handed over by the decoder
    typedef struct packed {
        logic [15:0] first_block_word;
        logic [15:0] second_block_word;
        logic [15:0] third_block_word;
        logic [15:0] fourth_block_word;
        logic        block_identity_is_e;
        logic [1:0]  first_block_error_level;
        logic [1:0]  second_block_error_level;
        logic [1:0]  third_block_error_level;
        logic [1:0]  fourth_block_error_level;
    } group_s;

    // synchronised view of the serial pins
    typedef struct packed {
        logic sclk;
        logic sclk_rise;
        logic sclk_fall;
        logic sen_n;
        logic sdio;
        logic mode;
    } pins_s;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser per pin plus edge detection on the clean copy
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk,   // core clock
    input  wire logic             rst_n,  // synchronised reset, active low
    input  wire logic [WIDTH-1:0] pin_in, // raw asynchronous pins
    output logic      [WIDTH-1:0] level,  // synchronised level
    output logic      [WIDTH-1:0] rise,   // one-cycle pulse on rising edge
    output logic      [WIDTH-1:0] fall    // one-cycle pulse on falling edge
);
    generate
        if (WIDTH < 1) begin : g_bad
            $error("pin_sync needs at least one pin");
        end
    endgenerate

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] last_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            // first stage feeds only the second; edges look at stages two and three
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[i] <= 1'b1;
                    level[i]    <= 1'b1;
                    last_reg[i] <= 1'b1;
                end else begin
                    meta_reg[i] <= pin_in[i];
                    level[i]    <= meta_reg[i];
                    last_reg[i] <= level[i];
                end
            end
            assign rise[i] = level[i] & ~last_reg[i];
            assign fall[i] = ~level[i] & last_reg[i];
        end
    endgenerate
endmodule

// file: rds_block_readout_status_asserts.sv
`timescale 1ns/1ps
// pin-level checks of the readout block
module rds_block_readout_status_asserts #(
    parameter int PULSE_CYCLES = 20
) (
    input wire logic mclk,                  // core clock
    input wire logic rst_n,                 // reset, active low
    input wire logic group_valid,           // new group
    input wire logic interface_mode,        // strap
    input wire logic sclk,                  // bus clock
    input wire logic serial_latch_enable_n, // frame
    input wire logic sdio_out,              // read data
    input wire logic sdio_oe,               // data enable
    input wire logic two_wire_selected,     // two-wire on
    input wire logic new_group_ready_flag   // ready flag
);
    int age;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // cycles since the last group, saturating so it never wraps
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) age <= 0;
        else if (group_valid) age <= 0;
        else if (age < PULSE_CYCLES + 8) age <= age + 1;
    end
    ready_set_a: assert property (group_valid |=> new_group_ready_flag)
        else $error("ready flag not set by group");
    pulse_len_a: assert property ($fell(new_group_ready_flag) && serial_latch_enable_n &&
        $past(serial_latch_enable_n, 8) |-> age inside {[PULSE_CYCLES - 1:PULSE_CYCLES + 1]})
        else $error("ready pulse width wrong");
    strap_low_a: assert property (!interface_mode [*8] |-> two_wire_selected)
        else $error("two-wire not selected");
    strap_high_a: assert property (interface_mode [*8] |-> !two_wire_selected)
        else $error("two-wire selected with strap high");
    oe_strap_a: assert property (!interface_mode [*8] |-> !sdio_oe)
        else $error("data driven in two-wire mode");
    oe_idle_a: assert property (serial_latch_enable_n [*8] |-> !sdio_oe)
        else $error("data driven outside frame");
    oe_rise_a: assert property ($rose(sdio_oe) |-> !serial_latch_enable_n && (sclk || $past(sclk)))
        else $error("data enable not after clock rise");
    data_shift_a: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out) |->
        !sclk || !$past(sclk)) else $error("read data moved on clock high");
    cover property (group_valid);
    cover property ($rose(sdio_oe));
    cover property ($fell(new_group_ready_flag) && serial_latch_enable_n);
endmodule
bind rds_block_readout_status rds_block_readout_status_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) chk (
    .mclk(mclk), .rst_n(rst_n), .group_valid(group_valid), .interface_mode(interface_mode), .sclk(sclk),
    .serial_latch_enable_n(serial_latch_enable_n), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .two_wire_selected(two_wire_selected), .new_group_ready_flag(new_group_ready_flag));

// file: host_serial_model.sv
`timescale 1ns/1ps
// host on the three-wire bus; clock idles low between frames
module host_serial_model (
    input  wire logic  mclk,          // core clock
    input  wire logic  dev_oe,        // device drives data
    input  wire logic  dev_out,       // device data
    output logic       sclk = 1'b0,   // bus clock
    output logic       sen_n = 1'b1,  // frame, active low
    output logic       sdio,          // resolved data line
    output logic       done = 1'b0,   // read word ready
    output logic [15:0] rdata = '0    // word read
);
    logic drv = 1'b0;
    logic hbit = 1'b0;
    logic tgl = 1'b0;
    // a released line has no pull, so show a changing pattern
    always_ff @(posedge mclk) tgl <= ~tgl;
    assign sdio = dev_oe ? dev_out : (drv ? hbit : tgl);
    // one 24-bit frame, 8 mclk per bit; read bits sampled late in high phase
    task automatic xfer(input logic rd, input logic [6:0] idx, input logic [15:0] wd);
        logic [23:0] fr;
        fr = {rd, idx, wd};
        @(posedge mclk);
        sen_n <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            drv <= !rd || i < 8;
            hbit <= fr[23 - i];
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            if (rd && i > 7) rdata[23 - i] <= sdio;
        end
        sclk <= 1'b0;
        drv <= 1'b0;
        repeat (4) @(posedge mclk);
        sen_n <= 1'b1;
        done <= rd;
        @(posedge mclk);
        done <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// file: rds_block_readout_status_tb.sv
`timescale 1ns/1ps
module rds_block_readout_status_tb;
    localparam int PULSE = 20;
    logic        rst_n, group_valid, station_detected, tuner_ready_flag, interface_mode, mclk;
    logic        sclk, sen_n, sdio, sdio_out, sdio_oe, two_wire_selected, flag, rbds_mode, done;
    logic [15:0] rdata;
    logic [38:0] expq[$];
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;
    rds_readout_pkg::group_s group_in;
    rds_block_readout_status #(.PULSE_CYCLES(PULSE)) DUT (.mclk(mclk), .rst_n(rst_n), .group_valid(group_valid),
        .group_in(group_in), .station_detected(station_detected), .tuner_ready_flag(tuner_ready_flag),
        .interface_mode(interface_mode), .sclk(sclk), .serial_latch_enable_n(sen_n), .sdio_in(sdio),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .two_wire_selected(two_wire_selected),
        .new_group_ready_flag(flag), .rbds_mode(rbds_mode));
    host_serial_model host (.mclk(mclk), .dev_oe(sdio_oe), .dev_out(sdio_out), .sclk(sclk), .sen_n(sen_n),
        .sdio(sdio), .done(done), .rdata(rdata));
    // 20 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // note the expectation, then run the read frame
    task automatic rd(input logic [6:0] idx, input logic [15:0] m, input logic [15:0] v);
        expq.push_back({idx, m, v});
        host.xfer(1'b1, idx, 16'h0);
    endtask
    task automatic send_group(output rds_readout_pkg::group_s g);
        g = 73'({$urandom, $urandom, $urandom});
        @(posedge mclk);
        group_valid <= 1'b1;
        group_in <= g;
        @(posedge mclk);
        group_valid <= 1'b0;
        @(posedge mclk);
    endtask
    // each finished read is paired with the oldest note
    always @(posedge mclk) begin
        logic [38:0] e;
        if (done) begin
            e = expq.pop_front();
            check($sformatf("reg %h", e[38:32]), rdata & e[31:16], e[15:0]);
        end
    end
    // hang guard, well above the roughly 9000 cycles of the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        rds_readout_pkg::group_s g;
        rst_n = 1'b0;
        group_valid = 1'b0;
        group_in = '0;
        station_detected = 1'b0;
        tuner_ready_flag = 1'b0;
        interface_mode = 1'b1;
        void'($urandom(32'hea3a));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        // reset values, unmapped index
        rd(7'h04, 16'hffff, 16'h0400);
        for (int j = 0; j < 5; j++) rd(7'h0c + 7'(j), 16'hffff, 16'h0000);
        rd(7'h20, 16'hffff, 16'h0000);
        // verbose off: error fields carry nothing, ready flag cleared by first word read
        send_group(g);
        rd(7'h10, 16'hf000, 16'h0000);
        rd(7'h0b, 16'h001f, {11'h0, g.block_identity_is_e, 4'h0});
        rd(7'h0a, 16'h8000, 16'h8000);
        rd(7'h0c, 16'hffff, g.first_block_word);
        @(negedge mclk);
        check("ready", {15'h0, flag}, 16'h0);
        host.xfer(1'b0, 7'h04, 16'h0480);
        for (int k = 0; k < 4; k++) begin
            station_detected <= 1'($urandom);
            tuner_ready_flag <= 1'($urandom);
            send_group(g);
            rd(7'h0b, 16'h019f, {7'h0, station_detected, tuner_ready_flag, 2'b0, g.block_identity_is_e,
                g.first_block_error_level, g.second_block_error_level});
            rd(7'h10, 16'hf000, {g.third_block_error_level, g.fourth_block_error_level, 12'h0});
            host.xfer(1'b0, 7'h0c + 7'(k), 16'($urandom));
            for (int j = 0; j < 4; j++) rd(7'h0c + 7'(j), 16'hffff, g[72 - 16 * j -: 16]);
        end
        // fixed-width pulse mode, rbds on
        host.xfer(1'b0, 7'h04, 16'h2080);
        check("rbds", {15'h0, rbds_mode}, 16'h1);
        send_group(g);
        repeat (PULSE - 4) @(posedge mclk);
        @(negedge mclk);
        check("pulse", {15'h0, flag}, 16'h1);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        check("pulse end", {15'h0, flag}, 16'h0);
        // strap low: block must stay off the three-wire bus
        interface_mode <= 1'b0;
        repeat (8) @(posedge mclk);
        check("two wire", {15'h0, two_wire_selected}, 16'h1);
        // a write with the strap low must not reach the control word
        host.xfer(1'b0, 7'h04, 16'h0400);
        interface_mode <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(7'h04, 16'hffff, 16'h2080);
        wrap_up();
    end
endmodule
